/* File: pkg/tmb_pkg.sv */
// Package: bank layout, constants, commands and carriers of the tag memory block
package tmb_pkg;
   // Bank sizes in 16-bit words, serial number width in bits and pointer width
   localparam int TID_WORDS = 11;
   localparam int EPC_WORDS = 10;
   localparam int RSV_WORDS = 4;
   localparam int SER_BITS = 48;
   localparam int ADDR_W = 21;
   // Bank codes on the air link
   localparam logic [1:0] BANK_RSV = 2'h0;
   localparam logic [1:0] BANK_EPC = 2'h1;
   localparam logic [1:0] BANK_TID = 2'h2;
   // Identification bank word positions
   localparam int TID_W_CLASS = 0;
   localparam int TID_W_MODEL = 1;
   localparam int TID_W_XHDR = 2;
   localparam int TID_W_SER = 3;
   localparam int TID_W_OPT = 6;
   localparam int TID_W_BLK = 7;
   localparam logic [15:0] XTID_HDR_VAL = 16'h3800;
   localparam logic [15:0] OPT_SUP_VAL = 16'h0cc8;
   localparam logic [63:0] BLK_SEG_VAL = 64'h0002_0308_0002_0302;
   // EPC bank word positions and defaults
   localparam int EPC_W_CRC = 0;
   localparam int EPC_W_PC = 1;
   localparam int EPC_W_SER = 5;
   localparam int PC_LEN_MSB = 15;
   localparam int PC_LEN_LSB = 11;
   localparam logic [15:0] PC_DEF_VAL = 16'h3000;
   // Reserved bank word positions
   localparam int RSV_W_KILL = 0;
   localparam int RSV_W_ACCESS = 2;
   // Error reply codes
   localparam logic [7:0] ERR_OTHER = 8'h00;
   localparam logic [7:0] ERR_OVERRUN = 8'h03;
   // Block command word-count limits
   localparam int BLKWR_MAX_DEF = 2;
   localparam int BLE_MAX_DEF = 8;
   // Random generator seed after reset
   localparam logic [15:0] RNG_SEED = 16'hace1;

   typedef enum logic [3:0] {
      cmd_query, cmd_query_rep, cmd_ack, cmd_nak, cmd_req_rn, cmd_select,
      cmd_read, cmd_write, block_write_cmd, cmd_block_erase, cmd_lock
   } tmb_cmd_t;

   typedef enum logic [2:0] {
      st_ready, st_arbitrate, st_reply, st_acknowledged, st_open, st_secured
   } tmb_state_t;

   typedef enum logic [1:0] {rsp_data, rsp_handle, rsp_done, rsp_error} tmb_rsp_kind_t;

   // Decoded command from the air front end
   typedef struct packed {
      logic valid;
      tmb_cmd_t cmd;
      logic [1:0] bank;
      logic [23:0] ebv;
      logic [7:0] count;
      logic [31:0] data;
      logic [15:0] handle;
      logic [3:0] q;
      logic target;
   } tmb_req_t;

   // Reply toward the air back end
   typedef struct packed {
      logic valid;
      tmb_rsp_kind_t kind;
      logic last;
      logic [15:0] word;
      logic [7:0] err;
   } tmb_rsp_t;
endpackage

/* File: verification/tmb_core_sva.sv */
// Checker: port-level assertions for the tag memory core
`timescale 1ns/10ps
`default_nettype none
module tmb_core_sva #(
   parameter int BLKWR_MAX = 2,
   parameter int BLE_MAX = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire tmb_pkg::tmb_req_t req,
   input wire tmb_pkg::tmb_rsp_t resp,
   input wire logic busy,
   input wire tmb_pkg::tmb_state_t tag_state
);
   logic [15:0] hnd_r;
   logic acc;
   logic e_oth;
   logic e_ovr;
   logic [6:0] ptr;
   // Last handle handed to the reader
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         hnd_r <= 16'h0;
      else if (resp.valid && resp.kind == tmb_pkg::rsp_handle)
         hnd_r <= resp.word;
   end
   // Access command taken inside an open session with the right handle
   assign acc = req.valid && !busy && req.handle == hnd_r &&
                (tag_state == tmb_pkg::st_open || tag_state == tmb_pkg::st_secured);
   assign e_oth = resp.kind == tmb_pkg::rsp_error && resp.err == tmb_pkg::ERR_OTHER;
   assign e_ovr = resp.kind == tmb_pkg::rsp_error && resp.err == tmb_pkg::ERR_OVERRUN;
   assign ptr = req.ebv[22:16];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_IDLE_ZERO: assert property (!resp.valid |-> resp == '0)
      else $error("reply fields not cleared while idle");
   AST_TID_WR_ERR: assert property (acc && req.bank == tmb_pkg::BANK_TID && req.cmd inside
      {tmb_pkg::cmd_write, tmb_pkg::block_write_cmd, tmb_pkg::cmd_block_erase} |=> resp.valid && e_oth)
      else $error("identification bank write not refused");
   AST_BLK_RSV_ERR: assert property (acc && req.bank == tmb_pkg::BANK_RSV && req.cmd inside
      {tmb_pkg::block_write_cmd, tmb_pkg::cmd_block_erase} |=> resp.valid && e_oth)
      else $error("block command on reserved bank not refused");
   AST_EPC_RANGE: assert property (acc && req.bank == tmb_pkg::BANK_EPC &&
      req.cmd == tmb_pkg::cmd_write && !req.ebv[23] && ptr >= 7'h0a |=> resp.valid && e_ovr)
      else $error("write past end of EPC bank not refused");
   AST_BLKWR_COUNT: assert property (acc && req.bank == tmb_pkg::BANK_EPC &&
      req.cmd == tmb_pkg::block_write_cmd && (req.count == 0 || req.count > BLKWR_MAX)
      |=> resp.valid && e_ovr) else $error("bad block write count not refused");
   AST_BLE_COUNT: assert property (acc && req.bank == tmb_pkg::BANK_EPC &&
      req.cmd == tmb_pkg::cmd_block_erase && (req.count == 0 || req.count > BLE_MAX)
      |=> resp.valid && e_ovr) else $error("bad block erase count not refused");
   AST_SYS_HIDDEN: assert property (acc && req.bank == 2'h3 &&
      req.cmd inside {tmb_pkg::cmd_read, tmb_pkg::cmd_write} |=> resp.valid &&
      ($past(req.cmd) == tmb_pkg::cmd_write ? e_oth : e_ovr))
      else $error("system area reached by read or write");
   AST_RSV_WRITE: assert property (acc && req.bank == tmb_pkg::BANK_RSV &&
      req.cmd == tmb_pkg::cmd_write && !req.ebv[23] && ptr < 7'h04 && req.count == 8'h01
      |=> resp.valid && resp.kind == tmb_pkg::rsp_done && resp.word == $past(req.handle))
      else $error("reserved bank write not acknowledged");
   AST_READ_START: assert property (acc && req.cmd == tmb_pkg::cmd_read &&
      req.bank == tmb_pkg::BANK_TID && req.count <= 8'h0b &&
      (req.ebv[23:16] == 8'h00 || req.ebv[23:8] == 16'h8000)
      |=> busy ##1 (resp.valid && resp.kind == tmb_pkg::rsp_data))
      else $error("read from word zero did not stream");
   AST_BUSY_LAST: assert property ($fell(busy) |-> resp.valid && resp.last &&
      resp.kind == tmb_pkg::rsp_data) else $error("busy fell without a last word");
endmodule
bind tmb_core tmb_core_sva #(.BLKWR_MAX(BLKWR_MAX), .BLE_MAX(BLE_MAX)) i_tmb_core_sva (
   .clk(clk), .reset_n(reset_n), .req(req), .resp(resp), .busy(busy), .tag_state(tag_state));
`default_nettype wire

/* File: verification/tmb_core_tb_top.sv */
// Testbench: tag memory core driven through the reader model
`timescale 1ns/10ps
`default_nettype none
module tmb_core_tb_top;
   localparam logic [7:0] CID = 8'h4b; // Arbitrary value
   localparam logic [11:0] MID = 12'h9d3; // Arbitrary value
   localparam logic [7:0] PID = 8'h61; // Arbitrary value
   localparam logic [3:0] SIV = 4'h2;
   localparam logic [47:0] SER = 48'h1a2b_3c4d_5e6f;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic prog_valid = 1'b0;
   logic [47:0] prog_serial = 48'h0;
   logic defaults_load = 1'b0;
   tmb_pkg::tmb_req_t req;
   tmb_pkg::tmb_rsp_t resp;
   tmb_pkg::tmb_state_t tag_state;
   logic busy;
   logic inv_flag;
   logic sel_flag;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   tmb_core #(.CLASS_ID(CID), .MAKER_ID(MID), .PART_CODE(PID), .SI_VER(SIV)) i_tmb_core (
      .clk(clk), .reset_n(reset_n), .req(req), .prog_valid(prog_valid),
      .prog_serial(prog_serial), .defaults_load(defaults_load), .resp(resp), .busy(busy),
      .tag_state(tag_state), .inv_flag(inv_flag), .sel_flag(sel_flag));
   tmb_reader i_tmb_reader (.clk(clk), .req(req), .resp(resp));
   // Clock and hang guard
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Compare a read stream against expected words
   task automatic rd(input logic [1:0] b, input logic [6:0] p, input logic [15:0] e[$]);
      i_tmb_reader.send(tmb_pkg::cmd_read, b, p, 8'h0, 32'h0, 1'b1);
      chk(16'(i_tmb_reader.words.size()), 16'(e.size()), "stream length");
      foreach (e[i]) chk(i_tmb_reader.words[i], e[i], "stream word");
   endtask
   // A command that must be refused with the given code
   task automatic rf(input tmb_pkg::tmb_cmd_t c, input logic [1:0] b, input logic [6:0] p,
                     input logic [7:0] n, input logic [7:0] er);
      i_tmb_reader.send(c, b, p, n, 32'h0, 1'b0);
      chk({6'h0, i_tmb_reader.last_r.kind, i_tmb_reader.last_r.err},
          {6'h0, tmb_pkg::rsp_error, er}, "refusal");
   endtask
   task automatic t_session();
      @(posedge clk);
      #1;
      prog_serial = SER;
      prog_valid = 1'b1;
      @(posedge clk);
      #1;
      prog_valid = 1'b0;
      defaults_load = 1'b1;
      @(posedge clk);
      #1;
      defaults_load = 1'b0;
      i_tmb_reader.send(tmb_pkg::cmd_query, 2'h0, 7'h0, 8'h0, 32'h0, 1'b0);
      chk(16'(i_tmb_reader.last_r.kind), 16'(tmb_pkg::rsp_handle), "query");
      i_tmb_reader.send(tmb_pkg::cmd_ack, 2'h0, 7'h0, 8'h0, 32'h0, 1'b0);
      chk(16'(i_tmb_reader.words.size()), 16'h0007, "ack length");
      chk(i_tmb_reader.words[0], 16'h3000, "ack pc");
      chk(i_tmb_reader.words[4], SER[47:32], "ack serial");
      i_tmb_reader.send(tmb_pkg::cmd_req_rn, 2'h0, 7'h0, 8'h0, 32'h0, 1'b0);
      chk(16'(tag_state), 16'(tmb_pkg::st_secured), "session state");
      $display("test session done");
   endtask
   task automatic t_banks();
      rd(tmb_pkg::BANK_TID, 7'h0, '{{CID, MID[11:4]}, {MID[3:0], PID, SIV}, 16'h3800,
         SER[47:32], SER[31:16], SER[15:0], 16'h0cc8, 16'h0002, 16'h0308, 16'h0002,
         16'h0302});
      rd(tmb_pkg::BANK_EPC, 7'h1, '{16'h3000, 16'h0, 16'h0, 16'h0, SER[47:32], SER[31:16],
         SER[15:0], 16'h0, 16'h0});
      $display("test banks done");
   endtask
   task automatic t_refuse();
      rf(tmb_pkg::cmd_write, tmb_pkg::BANK_TID, 7'h3, 8'h01, 8'h00);
      rf(tmb_pkg::block_write_cmd, tmb_pkg::BANK_RSV, 7'h0, 8'h01, 8'h00);
      rf(tmb_pkg::cmd_block_erase, tmb_pkg::BANK_TID, 7'h0, 8'h01, 8'h00);
      rf(tmb_pkg::cmd_write, 2'h3, 7'h0, 8'h01, 8'h00);
      rf(tmb_pkg::cmd_read, 2'h3, 7'h0, 8'h01, 8'h03);
      rf(tmb_pkg::cmd_write, tmb_pkg::BANK_EPC, 7'h0a, 8'h01, 8'h03);
      rf(tmb_pkg::cmd_read, tmb_pkg::BANK_RSV, 7'h04, 8'h01, 8'h03);
      rf(tmb_pkg::block_write_cmd, tmb_pkg::BANK_EPC, 7'h2, 8'h03, 8'h03);
      rf(tmb_pkg::cmd_block_erase, tmb_pkg::BANK_EPC, 7'h0, 8'h09, 8'h03);
      rf(tmb_pkg::cmd_block_erase, tmb_pkg::BANK_EPC, 7'h2, 8'h00, 8'h03);
      rf(tmb_pkg::cmd_write, tmb_pkg::BANK_EPC, 7'h2, 8'h02, 8'h03);
      $display("test refuse done");
   endtask
   task automatic t_write();
      i_tmb_reader.send(tmb_pkg::cmd_write, tmb_pkg::BANK_RSV, 7'h2, 8'h01, 32'hbeef_0000, 1'b0);
      chk(16'(i_tmb_reader.last_r.kind), 16'(tmb_pkg::rsp_done), "write done");
      rd(tmb_pkg::BANK_RSV, 7'h0, '{16'h0, 16'h0, 16'hbeef, 16'h0});
      i_tmb_reader.send(tmb_pkg::block_write_cmd, tmb_pkg::BANK_EPC, 7'h8, 8'h02, 32'hcafe_f00d, 1'b0);
      chk(16'(i_tmb_reader.last_r.kind), 16'(tmb_pkg::rsp_done), "block done");
      rd(tmb_pkg::BANK_EPC, 7'h7, '{SER[15:0], 16'hcafe, 16'hf00d});
      i_tmb_reader.send(tmb_pkg::cmd_block_erase, tmb_pkg::BANK_EPC, 7'h8, 8'h02, 32'h0, 1'b0);
      rd(tmb_pkg::BANK_EPC, 7'h8, '{16'h0, 16'h0});
      i_tmb_reader.send(tmb_pkg::cmd_lock, 2'h0, 7'h0, 8'h0, 32'h0000_5555, 1'b0);
      rf(tmb_pkg::cmd_read, 2'h3, 7'h0, 8'h01, 8'h03);
      // Query from a session flips the inventoried flag and drops to ready
      i_tmb_reader.send(tmb_pkg::cmd_query, 2'h0, 7'h0, 8'h0, 32'h0, 1'b0);
      chk(16'(inv_flag), 16'h0001, "inventoried flag");
      i_tmb_reader.send(tmb_pkg::cmd_select, tmb_pkg::BANK_TID, 7'h2, 8'h0, 32'hffff_3800, 1'b0);
      chk(16'(sel_flag), 16'h0001, "select tid");
      i_tmb_reader.send(tmb_pkg::cmd_select, tmb_pkg::BANK_RSV, 7'h0, 8'h0, 32'h0, 1'b0);
      chk(16'(sel_flag), 16'h0000, "select reserved");
      $display("test write done");
   endtask
   // Reset, then the scenarios in turn
   initial
   begin
      repeat (5) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_session();
      t_banks();
      t_refuse();
      t_write();
      end_sim();
   end
endmodule
`default_nettype wire

/* File: verification/tmb_reader.sv */
// Reader model: sends decoded commands and gathers replies
`timescale 1ns/10ps
`default_nettype none
module tmb_reader (
   input wire logic clk,
   output var tmb_pkg::tmb_req_t req,
   input wire tmb_pkg::tmb_rsp_t resp
);
   logic [15:0] words[$];
   tmb_pkg::tmb_rsp_t last_r;
   logic [15:0] handle;
   // Idle request at power-up
   initial
   begin
      req = '0;
      handle = 16'h0;
   end
   // One command for one cycle, then collect the reply or the word stream
   task automatic send(input tmb_pkg::tmb_cmd_t c, input logic [1:0] b, input logic [6:0] p,
                       input logic [7:0] n, input logic [31:0] d, input logic ext);
      words.delete();
      last_r = '0;
      @(posedge clk);
      #1;
      req = '0;
      req.valid = 1'b1;
      req.cmd = c;
      req.bank = b;
      req.count = n;
      req.data = d;
      req.handle = handle;
      req.ebv = ext ? {8'h80, 1'b0, p, 8'h00} : {1'b0, p, 16'h0};
      @(posedge clk);
      #1;
      req = {1'b0, ~req[$bits(req)-2:0]}; // Released fields stop showing the old value
      for (int k = 0; k < 30; k++)
      begin
         @(negedge clk);
         if (resp.valid)
         begin
            last_r = resp;
            if (resp.kind == tmb_pkg::rsp_data) words.push_back(resp.word);
            if (resp.kind == tmb_pkg::rsp_handle) handle = resp.word;
            if (resp.kind != tmb_pkg::rsp_data || resp.last) break;
         end
      end
   endtask
endmodule
`default_nettype wire

/* File: verilog/tmb_core.sv */
// Tag memory banks, access policy and inventory control of a UHF tag
`timescale 1ns/10ps
`default_nettype none

module tmb_core #(
   parameter logic [7:0] CLASS_ID = 8'h5a,     // Arbitrary value
   parameter logic [11:0] MAKER_ID = 12'h123,  // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3c,    // Arbitrary value
   parameter logic [3:0] SI_VER = 4'h1,
   parameter int BLKWR_MAX = tmb_pkg::BLKWR_MAX_DEF,
   parameter int BLE_MAX = tmb_pkg::BLE_MAX_DEF
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire tmb_pkg::tmb_req_t req,
   input wire logic prog_valid,
   input wire logic [tmb_pkg::SER_BITS-1:0] prog_serial,
   input wire logic defaults_load,
   output var tmb_pkg::tmb_rsp_t resp,
   output logic busy,
   output var tmb_pkg::tmb_state_t tag_state,
   output logic inv_flag,
   output logic sel_flag
);
   localparam int AW = tmb_pkg::ADDR_W;
   typedef logic [tmb_pkg::TID_WORDS-1:0][15:0] tmb_tid_arr_t;
   typedef logic [tmb_pkg::EPC_WORDS-1:0][15:0] tmb_epc_arr_t;
   typedef logic [tmb_pkg::RSV_WORDS-1:0][15:0] tmb_rsv_arr_t;

   // Refuse block limits the EPC bank cannot serve
   if (BLKWR_MAX < 1 || BLKWR_MAX > tmb_pkg::EPC_WORDS || BLE_MAX < 1
       || BLE_MAX > tmb_pkg::EPC_WORDS)
   begin : g_chk
      $error("tmb_core: block word-count limit out of range");
   end

   // Decode an EBV-8 pointer of one to three bytes, first byte in the top bits
   function automatic logic [AW:0] ebv_decode(input logic [23:0] v);
      logic [AW:0] r;
      r = '0;
      if (!v[23])
         r = {1'b1, 14'h0, v[22:16]};
      else if (!v[15])
         r = {1'b1, 7'h0, v[22:16], v[14:8]};
      else if (!v[7])
         r = {1'b1, v[22:16], v[14:8], v[6:0]};
      return r;
   endfunction

   // Size of a bank in words, zero for the unused code
   function automatic logic [AW:0] bank_words(input logic [1:0] b);
      logic [AW:0] n;
      n = '0;
      if (b == tmb_pkg::BANK_TID)
         n = (AW+1)'(tmb_pkg::TID_WORDS);
      else if (b == tmb_pkg::BANK_EPC)
         n = (AW+1)'(tmb_pkg::EPC_WORDS);
      else if (b == tmb_pkg::BANK_RSV)
         n = (AW+1)'(tmb_pkg::RSV_WORDS);
      return n;
   endfunction

   // Fetch one word of a bank; top bit marks a hit
   function automatic logic [16:0] word_at(input logic [1:0] b, input logic [AW-1:0] a,
                                           input tmb_tid_arr_t t, input tmb_epc_arr_t e,
                                           input tmb_rsv_arr_t r);
      logic [16:0] w;
      w = '0;
      if ({1'b0, a} < bank_words(b))
      begin
         if (b == tmb_pkg::BANK_TID)
            w = {1'b1, t[a[3:0]]};
         else if (b == tmb_pkg::BANK_EPC)
            w = {1'b1, e[a[3:0]]};
         else
            w = {1'b1, r[a[1:0]]};
      end
      return w;
   endfunction

   // Factory EPC image built around a serial number
   function automatic tmb_epc_arr_t epc_default(input logic [47:0] s);
      tmb_epc_arr_t e;
      e = '0;
      e[tmb_pkg::EPC_W_PC] = tmb_pkg::PC_DEF_VAL;
      e[tmb_pkg::EPC_W_SER] = s[47:32];
      e[tmb_pkg::EPC_W_SER+1] = s[31:16];
      e[tmb_pkg::EPC_W_SER+2] = s[15:0];
      return e;
   endfunction

   // Build a valid reply
   function automatic tmb_pkg::tmb_rsp_t mk_rsp(input tmb_pkg::tmb_rsp_kind_t k,
                                                input logic l, input logic [15:0] w,
                                                input logic [7:0] er);
      tmb_pkg::tmb_rsp_t p;
      p.valid = 1'b1;
      p.kind = k;
      p.last = l;
      p.word = w;
      p.err = er;
      return p;
   endfunction

   logic [tmb_pkg::SER_BITS-1:0] serial_r;
   tmb_epc_arr_t epc_r;
   tmb_rsv_arr_t rsv_r;
   logic [15:0] sys_r;
   logic [15:0] rng_r;
   logic [15:0] handle_r;
   logic [15:0] slot_r;
   logic [1:0] rd_bank_r;
   logic [AW-1:0] rd_ptr_r;
   logic [7:0] rd_left_r;
   tmb_tid_arr_t tid_w;
   logic [AW:0] ptr_dec;
   logic [AW-1:0] ptr;
   logic [AW:0] span;
   logic [7:0] rd_cnt;
   logic ptr_ok, hmatch, in_acc, fits, take, do_wr, do_blk, sel_match, acc_pwd_zero;
   logic [16:0] sel_word, rd_word;
   logic [15:0] nslot, qmask;

   // Identification bank: constants around the stored serial
   always_comb
   begin
      tid_w = '0;
      tid_w[tmb_pkg::TID_W_CLASS] = {CLASS_ID, MAKER_ID[11:4]};
      tid_w[tmb_pkg::TID_W_MODEL] = {MAKER_ID[3:0], PART_CODE, SI_VER};
      tid_w[tmb_pkg::TID_W_XHDR] = tmb_pkg::XTID_HDR_VAL;
      tid_w[tmb_pkg::TID_W_SER] = serial_r[47:32];
      tid_w[tmb_pkg::TID_W_SER+1] = serial_r[31:16];
      tid_w[tmb_pkg::TID_W_SER+2] = serial_r[15:0];
      tid_w[tmb_pkg::TID_W_OPT] = tmb_pkg::OPT_SUP_VAL;
      tid_w[tmb_pkg::TID_W_BLK] = tmb_pkg::BLK_SEG_VAL[63:48];
      tid_w[tmb_pkg::TID_W_BLK+1] = tmb_pkg::BLK_SEG_VAL[47:32];
      tid_w[tmb_pkg::TID_W_BLK+2] = tmb_pkg::BLK_SEG_VAL[31:16];
      tid_w[tmb_pkg::TID_W_BLK+3] = tmb_pkg::BLK_SEG_VAL[15:0];
   end

   // Request decode: pointer, range, permission and select compare
   always_comb
   begin
      ptr_dec = ebv_decode(req.ebv);
      ptr_ok = ptr_dec[AW];
      ptr = ptr_dec[AW-1:0];
      take = req.valid && !busy;
      hmatch = req.handle == handle_r;
      in_acc = (tag_state == tmb_pkg::st_open || tag_state == tmb_pkg::st_secured) && hmatch;
      // Zero count reads to the end of the bank
      if (req.count == 8'h00 && {1'b0, ptr} < bank_words(req.bank))
         rd_cnt = 8'(bank_words(req.bank) - {1'b0, ptr});
      else
         rd_cnt = req.count;
      span = {1'b0, ptr} + (AW+1)'(rd_cnt);
      fits = ptr_ok && rd_cnt != 8'h00 && span <= bank_words(req.bank);
      do_wr = take && in_acc && req.cmd == tmb_pkg::cmd_write && req.count == 8'h01 && fits
              && (req.bank == tmb_pkg::BANK_EPC || req.bank == tmb_pkg::BANK_RSV);
      do_blk = take && in_acc && req.bank == tmb_pkg::BANK_EPC && fits
               && req.count != 8'h00
               && ((req.cmd == tmb_pkg::block_write_cmd && int'(req.count) <= BLKWR_MAX)
                   || (req.cmd == tmb_pkg::cmd_block_erase && int'(req.count) <= BLE_MAX));
      sel_word = word_at(req.bank, ptr, tid_w, epc_r, rsv_r);
      sel_match = ptr_ok && req.bank != tmb_pkg::BANK_RSV && sel_word[16]
                  && ((sel_word[15:0] ^ req.data[15:0]) & req.data[31:16]) == 16'h0000;
      rd_word = word_at(rd_bank_r, rd_ptr_r, tid_w, epc_r, rsv_r);
      acc_pwd_zero = {rsv_r[tmb_pkg::RSV_W_ACCESS], rsv_r[tmb_pkg::RSV_W_ACCESS+1]} == 32'h0;
      qmask = 16'((17'h00001 << req.q) - 17'h00001);
      nslot = rng_r & qmask;
   end

   // Serial number: the only writable identification storage
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         serial_r <= '0;
      else if (prog_valid)
         serial_r <= prog_serial;
   end

   // EPC, reserved and system storage
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         epc_r <= epc_default(48'h0);
         rsv_r <= '0;
         sys_r <= '0;
      end
      else if (defaults_load)
      begin
         epc_r <= epc_default(serial_r);
         rsv_r <= '0;
      end
      else
      begin
         if (do_wr && req.bank == tmb_pkg::BANK_EPC)
            epc_r[ptr[3:0]] <= req.data[31:16];
         if (do_wr && req.bank == tmb_pkg::BANK_RSV)
            rsv_r[ptr[1:0]] <= req.data[31:16];
         if (do_blk)
         begin
            for (int i = 0; i < tmb_pkg::EPC_WORDS; i++)
            begin
               if (AW'(i) >= ptr && (AW+1)'(i) < span)
               begin
                  if (req.cmd == tmb_pkg::cmd_block_erase)
                     epc_r[i] <= 16'h0000;
                  else if (AW'(i) == ptr)
                     epc_r[i] <= req.data[31:16];
                  else
                     epc_r[i] <= req.data[15:0];
               end
            end
         end
         if (take && in_acc && req.cmd == tmb_pkg::cmd_lock)
            sys_r <= req.data[15:0];
      end
   end

   // Free-running 16-bit random generator
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rng_r <= tmb_pkg::RNG_SEED;
      else
         rng_r <= {rng_r[14:0], rng_r[15] ^ rng_r[13] ^ rng_r[12] ^ rng_r[10]};
   end

   // Tag states, slot counter, flags, read streaming and replies
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tag_state <= tmb_pkg::st_ready;
         slot_r <= '0;
         handle_r <= '0;
         inv_flag <= 1'b0;
         sel_flag <= 1'b0;
         resp <= '0;
         busy <= 1'b0;
         rd_bank_r <= '0;
         rd_ptr_r <= '0;
         rd_left_r <= '0;
      end
      else
      begin
         resp <= '0;
         if (busy)
         begin
            // One word per cycle, system word is never a source
            resp <= mk_rsp(tmb_pkg::rsp_data, rd_left_r == 8'h01, rd_word[15:0], 8'h00);
            rd_ptr_r <= rd_ptr_r + AW'(1);
            rd_left_r <= rd_left_r - 8'h01;
            busy <= rd_left_r != 8'h01;
         end
         else if (req.valid)
         begin
            case (req.cmd)
               tmb_pkg::cmd_query:
               begin
                  handle_r <= rng_r;
                  if (tag_state >= tmb_pkg::st_acknowledged)
                     inv_flag <= ~inv_flag;
                  if ((tag_state >= tmb_pkg::st_acknowledged ? ~inv_flag : inv_flag)
                      != req.target)
                     tag_state <= tmb_pkg::st_ready;
                  else if (nslot == 16'h0000)
                  begin
                     tag_state <= tmb_pkg::st_reply;
                     resp <= mk_rsp(tmb_pkg::rsp_handle, 1'b1, rng_r, 8'h00);
                  end
                  else
                  begin
                     tag_state <= tmb_pkg::st_arbitrate;
                     slot_r <= nslot;
                  end
               end
               tmb_pkg::cmd_query_rep:
               begin
                  if (tag_state == tmb_pkg::st_arbitrate)
                  begin
                     slot_r <= slot_r - 16'h0001;
                     if (slot_r == 16'h0001)
                     begin
                        tag_state <= tmb_pkg::st_reply;
                        handle_r <= rng_r;
                        resp <= mk_rsp(tmb_pkg::rsp_handle, 1'b1, rng_r, 8'h00);
                     end
                  end
                  else if (tag_state == tmb_pkg::st_reply)
                     tag_state <= tmb_pkg::st_arbitrate;
                  else if (tag_state != tmb_pkg::st_ready)
                  begin
                     inv_flag <= ~inv_flag;
                     tag_state <= tmb_pkg::st_ready;
                  end
               end
               tmb_pkg::cmd_ack:
               begin
                  if (tag_state != tmb_pkg::st_ready && tag_state != tmb_pkg::st_arbitrate)
                  begin
                     if (hmatch)
                     begin
                        // Backscatter PC and the EPC words it announces
                        if (tag_state == tmb_pkg::st_reply)
                           tag_state <= tmb_pkg::st_acknowledged;
                        rd_bank_r <= tmb_pkg::BANK_EPC;
                        rd_ptr_r <= AW'(tmb_pkg::EPC_W_PC);
                        rd_left_r <= 8'(epc_r[tmb_pkg::EPC_W_PC][tmb_pkg::PC_LEN_MSB:
                                                                 tmb_pkg::PC_LEN_LSB]) + 8'h01;
                        busy <= 1'b1;
                     end
                     else
                        tag_state <= tmb_pkg::st_arbitrate;
                  end
               end
               tmb_pkg::cmd_nak:
               begin
                  if (tag_state != tmb_pkg::st_ready)
                     tag_state <= tmb_pkg::st_arbitrate;
               end
               tmb_pkg::cmd_req_rn:
               begin
                  if (hmatch && tag_state == tmb_pkg::st_acknowledged)
                  begin
                     handle_r <= rng_r;
                     tag_state <= acc_pwd_zero ? tmb_pkg::st_secured : tmb_pkg::st_open;
                     resp <= mk_rsp(tmb_pkg::rsp_handle, 1'b1, rng_r, 8'h00);
                  end
                  else if (in_acc)
                     resp <= mk_rsp(tmb_pkg::rsp_handle, 1'b1, rng_r, 8'h00);
               end
               tmb_pkg::cmd_select:
               begin
                  sel_flag <= sel_match;
                  tag_state <= tmb_pkg::st_ready;
               end
               tmb_pkg::cmd_read:
               begin
                  if (in_acc && fits)
                  begin
                     rd_bank_r <= req.bank;
                     rd_ptr_r <= ptr;
                     rd_left_r <= rd_cnt;
                     busy <= 1'b1;
                  end
                  else if (in_acc)
                     resp <= mk_rsp(tmb_pkg::rsp_error, 1'b1, 16'h0000, tmb_pkg::ERR_OVERRUN);
               end
               tmb_pkg::cmd_write, tmb_pkg::block_write_cmd, tmb_pkg::cmd_block_erase:
               begin
                  if (do_wr || do_blk)
                     resp <= mk_rsp(tmb_pkg::rsp_done, 1'b1, handle_r, 8'h00);
                  else if (in_acc && (req.bank == tmb_pkg::BANK_TID
                           || req.bank == 2'h3 || (req.cmd != tmb_pkg::cmd_write
                           && req.bank != tmb_pkg::BANK_EPC)))
                     resp <= mk_rsp(tmb_pkg::rsp_error, 1'b1, 16'h0000, tmb_pkg::ERR_OTHER);
                  else if (in_acc)
                     resp <= mk_rsp(tmb_pkg::rsp_error, 1'b1, 16'h0000,
                                    tmb_pkg::ERR_OVERRUN);
               end
               tmb_pkg::cmd_lock:
               begin
                  if (in_acc)
                     resp <= mk_rsp(tmb_pkg::rsp_done, 1'b1, handle_r, 8'h00);
               end
               default:
               begin
                  resp <= '0;
               end
            endcase
         end
      end
   end
endmodule

`default_nettype wire
